// ==== hdl/usc_pkg.sv ====
package usc_pkg;

   // ---------------------------------------------------------------
   // sizes and codes
   // ---------------------------------------------------------------
   localparam int USC_DATA_W = 16;
   localparam int USC_N_IN = 4;
   localparam int USC_N_DAT = 2;
   localparam int USC_IN_DAT0 = 0;
   localparam int USC_IN_DAT1 = 1;
   localparam int USC_IN_CTL0 = 2;
   localparam int USC_IN_CLK = 3;
   localparam logic [2:0] USC_PROT_OFF = 3'h0;
   localparam logic [2:0] USC_PROT_SPI = 3'h1;
   localparam logic [2:0] USC_PROT_UART = 3'h2;
   localparam logic [2:0] USC_PROT_I2C = 3'h4;
   localparam logic [1:0] USC_EDGE_NONE = 2'h0;
   localparam logic [1:0] USC_EDGE_RISE = 2'h1;
   localparam logic [1:0] USC_EDGE_FALL = 2'h2;
   localparam logic [1:0] USC_RX_DEPTH = 2'h2;
   localparam logic [4:0] USC_BIT_STEP = 5'h01;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] protocol_select;
      logic master;
      logic flow_ctrl;
      logic half_duplex;
      logic [3:0] word_len;
      logic msb_first;
      logic data_invert;
      logic ctrl_invert;
      logic data_sync;
      logic ctrl_sync;
      logic clk_sync;
      logic [1:0] edge_detect_sel;
   } usc_cfg_s;

   typedef struct packed {
      logic data_pin_direction;
      logic [USC_DATA_W-1:0] data;
   } usc_tx_word_s;

   typedef enum logic [0:0] {
      USC_LK_IDLE = 1'b0,
      USC_LK_SHIFT = 1'b1
   } usc_lk_state_e;

   // ---------------------------------------------------------------
   // state of the peripheral clock side
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [USC_N_IN-1:0] sy1, sy2, sy3, filt;
      logic [USC_N_DAT-1:0] edge_prev, trig;
      logic [USC_DATA_W-1:0] tx_hold;
      logic tx_dir, tx_empty, tx_req;
      logic [2:0] ack_s, st_s, end_s, rx_s;
      logic [USC_DATA_W-1:0] rx_h0, rx_h1;
      logic [1:0] rx_cnt;
      logic rx_ovr, tx_st_f, tx_end_f;
      logic clk_out, clk_oe_n, rts_n, rts_oe_n;
   } usc_core_s;

   // ---------------------------------------------------------------
   // state of the link clock side
   // ---------------------------------------------------------------
   typedef struct packed {
      logic rst1, rst2, req1, req2;
      usc_cfg_s cfg1, cfg2;
      usc_lk_state_e st;
      logic ack, st_tg, end_tg, rx_tg, loaded, dir, tx_bit;
      logic [4:0] cnt;
      logic [USC_DATA_W-1:0] tx_sh, rx_sh, rx_word;
      logic d0_out, d0_oe_n, d1_out, d1_oe_n, c0_out, c0_oe_n;
   } usc_link_s;

   localparam usc_core_s USC_CORE_RST = '{default: '0, tx_empty: 1'b1, clk_oe_n: 1'b1,
      rts_n: 1'b1, rts_oe_n: 1'b1};
   localparam usc_link_s USC_LINK_RST = '{default: '0, st: USC_LK_IDLE, tx_bit: 1'b1,
      d0_out: 1'b1, d0_oe_n: 1'b1, d1_out: 1'b1, d1_oe_n: 1'b1, c0_out: 1'b1, c0_oe_n: 1'b1};

endpackage

// ==== hdl/usc_serial_core.sv ====
module usc_serial_core (
   // clocks and reset
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_link_clock,
   // configuration
   input wire usc_pkg::usc_cfg_s i_cfg,
   // transmit data
   input wire logic i_tx_write,
   input wire usc_pkg::usc_tx_word_s i_tx_word,
   input wire logic i_tx_buf_clear,
   // receive data
   input wire logic i_rx_read,
   output logic [usc_pkg::USC_DATA_W-1:0] o_rx_data,
   output logic o_rx_valid,
   output logic o_rx_full,
   // status flags and their clears
   output logic o_tx_buf_full,
   output logic o_tx_buf_empty,
   output logic o_tx_start_flag,
   output logic o_tx_end_flag,
   output logic o_rx_overrun_flag,
   input wire logic i_tx_start_flag_clear,
   input wire logic i_tx_end_flag_clear,
   input wire logic i_rx_overrun_clear,
   // conditioned inputs for the protocol machines
   output logic [usc_pkg::USC_N_IN-1:0] o_cond_in,
   output logic [usc_pkg::USC_N_DAT-1:0] o_edge_trigger,
   // clock generator level
   input wire logic i_sclk_gen,
   // serial clock pin
   input wire logic i_serial_clock_pin,
   output logic o_serial_clock_pin,
   output logic o_serial_clock_pin_oe_n,
   // control pins
   input wire logic i_ctrl_pin_0,
   output logic o_ctrl_pin_0,
   output logic o_ctrl_pin_0_oe_n,
   output logic o_ctrl_pin_1,
   output logic o_ctrl_pin_1_oe_n,
   // data pins
   input wire logic i_data_pin_0,
   output logic o_data_pin_0,
   output logic o_data_pin_0_oe_n,
   input wire logic i_data_pin_1,
   output logic o_data_pin_1,
   output logic o_data_pin_1_oe_n
);

   // ---------------------------------------------------------------
   // peripheral clock side
   // ---------------------------------------------------------------
   usc_pkg::usc_core_s cq, cd;
   usc_pkg::usc_link_s lq, ld;

   logic [usc_pkg::USC_N_IN-1:0] raw_in, inv_in, sync_sel, cond_in;
   logic [usc_pkg::USC_N_DAT-1:0] edge_rise, edge_fall;
   logic c_spi, c_uart, c_i2c, c_on;
   logic ack_ev, st_ev, end_ev, rx_ev, pending, cts_ok, may_start, rx_rd;
   logic [1:0] rx_left;

   // pin order matches the channel indices
   assign raw_in = {i_serial_clock_pin, i_ctrl_pin_0, i_data_pin_1, i_data_pin_0};
   assign inv_in = {1'b0, i_cfg.ctrl_invert, {2{i_cfg.data_invert}}};
   assign sync_sel = {i_cfg.clk_sync, i_cfg.ctrl_sync, {2{i_cfg.data_sync}}};
   assign edge_rise = cond_in[1:0] & ~cq.edge_prev;
   assign edge_fall = ~cond_in[1:0] & cq.edge_prev;

   assign c_on = i_cfg.protocol_select != usc_pkg::USC_PROT_OFF;
   assign c_spi = i_cfg.protocol_select == usc_pkg::USC_PROT_SPI;
   assign c_uart = i_cfg.protocol_select == usc_pkg::USC_PROT_UART;
   assign c_i2c = i_cfg.protocol_select == usc_pkg::USC_PROT_I2C;

   // toggles from the link side, sampled after two stages
   assign ack_ev = cq.ack_s[1] ^ cq.ack_s[2];
   assign st_ev = cq.st_s[1] ^ cq.st_s[2];
   assign end_ev = cq.end_s[1] ^ cq.end_s[2];
   assign rx_ev = cq.rx_s[1] ^ cq.rx_s[2];
   assign pending = cq.tx_req ^ cq.ack_s[1];

   // clear-to-send is active low on control pin 0
   assign cts_ok = !(c_uart && i_cfg.flow_ctrl) || !cond_in[usc_pkg::USC_IN_CTL0];
   assign may_start = c_on && !cq.tx_empty && !pending && !ack_ev
      && (c_spi || c_uart || c_i2c) && cts_ok;
   assign rx_rd = i_rx_read && (cq.rx_cnt != 2'h0);
   assign rx_left = rx_rd ? cq.rx_cnt - 2'h1 : cq.rx_cnt;

   always_comb begin
      cd = cq;
      // ---------------------------------------------------------------
      // input conditioning
      // ---------------------------------------------------------------
      for (int i = 0; i < usc_pkg::USC_N_IN; i++) begin
         cd.sy1[i] = raw_in[i];
         cd.sy2[i] = cq.sy1[i];
         cd.sy3[i] = cq.sy2[i];
         if (cq.sy2[i] == cq.sy3[i]) begin
            cd.filt[i] = cq.sy2[i];
         end
         cond_in[i] = (sync_sel[i] ? cq.filt[i] : raw_in[i]) ^ inv_in[i];
      end
      cd.edge_prev = cond_in[1:0];
      case (i_cfg.edge_detect_sel)
         usc_pkg::USC_EDGE_NONE: cd.trig = '0;
         usc_pkg::USC_EDGE_RISE: cd.trig = edge_rise;
         usc_pkg::USC_EDGE_FALL: cd.trig = edge_fall;
         default: cd.trig = edge_rise | edge_fall;
      endcase

      // ---------------------------------------------------------------
      // crossings from the link side
      // ---------------------------------------------------------------
      cd.ack_s = {cq.ack_s[1:0], lq.ack};
      cd.st_s = {cq.st_s[1:0], lq.st_tg};
      cd.end_s = {cq.end_s[1:0], lq.end_tg};
      cd.rx_s = {cq.rx_s[1:0], lq.rx_tg};

      // ---------------------------------------------------------------
      // transmit holding buffer
      // ---------------------------------------------------------------
      if (may_start) begin
         cd.tx_req = ~cq.tx_req;
      end
      if (ack_ev || i_tx_buf_clear) begin
         cd.tx_empty = 1'b1;
      end
      if (i_tx_write) begin
         cd.tx_hold = i_tx_word.data;
         cd.tx_dir = i_tx_word.data_pin_direction;
         cd.tx_empty = 1'b0;
      end

      // ---------------------------------------------------------------
      // sticky flags, set wins over clear
      // ---------------------------------------------------------------
      if (i_tx_start_flag_clear) begin
         cd.tx_st_f = 1'b0;
      end
      if (st_ev) begin
         cd.tx_st_f = 1'b1;
      end
      if (i_tx_end_flag_clear) begin
         cd.tx_end_f = 1'b0;
      end
      if (end_ev) begin
         cd.tx_end_f = 1'b1;
      end
      if (i_rx_overrun_clear) begin
         cd.rx_ovr = 1'b0;
      end

      // ---------------------------------------------------------------
      // receive double buffer
      // ---------------------------------------------------------------
      if (rx_rd) begin
         cd.rx_h0 = cq.rx_h1;
      end
      cd.rx_cnt = rx_left;
      if (rx_ev) begin
         if (rx_left == usc_pkg::USC_RX_DEPTH) begin
            cd.rx_ovr = 1'b1;
         end else begin
            if (rx_left == 2'h0) begin
               cd.rx_h0 = lq.rx_word;
            end else begin
               cd.rx_h1 = lq.rx_word;
            end
            cd.rx_cnt = rx_left + 2'h1;
         end
      end

      // ---------------------------------------------------------------
      // clock and request-to-send pins
      // ---------------------------------------------------------------
      cd.rts_n = cd.rx_cnt == usc_pkg::USC_RX_DEPTH;
      cd.rts_oe_n = !(c_uart && i_cfg.flow_ctrl);
      cd.clk_out = 1'b0;
      cd.clk_oe_n = 1'b1;
      if (c_spi) begin
         cd.clk_out = i_sclk_gen;
         cd.clk_oe_n = !i_cfg.master;
      end else if (c_i2c) begin
         cd.clk_oe_n = !i_cfg.master || i_sclk_gen;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         cq <= usc_pkg::USC_CORE_RST;
      end else begin
         cq <= cd;
      end
   end

   // ---------------------------------------------------------------
   // link clock side: data shift unit
   // ---------------------------------------------------------------
   usc_pkg::usc_cfg_s lc;
   logic l_spi, l_slave, ss_act, l_pend, start_ok, rx_bit, do_load;
   logic [4:0] nbits;

   function automatic logic [3:0] usc_bit_idx(input logic msb, input logic [4:0] nb,
                                              input logic [4:0] n);
      logic [4:0] r;
      r = msb ? nb - usc_pkg::USC_BIT_STEP - n : n;
      return r[3:0];
   endfunction

   assign lc = lq.cfg2;
   assign l_spi = lc.protocol_select == usc_pkg::USC_PROT_SPI;
   assign l_slave = l_spi && !lc.master;
   assign ss_act = l_slave && !(i_ctrl_pin_0 ^ lc.ctrl_invert);
   assign l_pend = lq.req2 ^ lq.ack;
   assign start_ok = (lc.protocol_select != usc_pkg::USC_PROT_OFF)
      && (l_slave ? ss_act : l_pend);
   assign nbits = {1'b0, lc.word_len} + usc_pkg::USC_BIT_STEP;
   assign rx_bit = ((l_spi && lc.master && !lc.half_duplex) ? i_data_pin_1 : i_data_pin_0)
      ^ lc.data_invert;

   always_comb begin
      ld = lq;
      do_load = 1'b0;
      case (lq.st)
         usc_pkg::USC_LK_IDLE: begin
            do_load = start_ok;
         end
         usc_pkg::USC_LK_SHIFT: begin
            if (l_slave && !ss_act) begin
               ld.rx_word = lq.rx_sh;
               ld.rx_tg = ~lq.rx_tg;
               ld.st = usc_pkg::USC_LK_IDLE;
               ld.tx_bit = 1'b1;
            end else if (lq.cnt == nbits) begin
               ld.rx_word = lq.rx_sh;
               ld.rx_tg = ~lq.rx_tg;
               if (lq.loaded) begin
                  ld.end_tg = ~lq.end_tg;
               end
               ld.st = usc_pkg::USC_LK_IDLE;
               ld.tx_bit = 1'b1;
               do_load = start_ok;
            end else begin
               ld.rx_sh[usc_bit_idx(lc.msb_first, nbits, lq.cnt)] = rx_bit;
               ld.tx_bit = lq.tx_sh[usc_bit_idx(lc.msb_first, nbits, lq.cnt)];
               ld.cnt = lq.cnt + usc_pkg::USC_BIT_STEP;
            end
         end
         default: ld.st = usc_pkg::USC_LK_IDLE;
      endcase

      if (do_load) begin
         ld.st = usc_pkg::USC_LK_SHIFT;
         ld.cnt = usc_pkg::USC_BIT_STEP;
         ld.loaded = l_pend;
         ld.rx_sh = '0;
         ld.rx_sh[usc_bit_idx(lc.msb_first, nbits, 5'h00)] = rx_bit;
         ld.tx_sh = '1;
         ld.dir = 1'b0;
         if (l_pend) begin
            ld.tx_sh = cq.tx_hold;
            ld.dir = cq.tx_dir;
            ld.ack = ~lq.ack;
            ld.st_tg = ~lq.st_tg;
         end
         ld.tx_bit = ld.tx_sh[usc_bit_idx(lc.msb_first, nbits, 5'h00)];
      end

      // ---------------------------------------------------------------
      // output pin mapping
      // ---------------------------------------------------------------
      ld.d0_out = 1'b1;
      ld.d0_oe_n = 1'b1;
      ld.d1_out = 1'b1;
      ld.d1_oe_n = 1'b1;
      ld.c0_out = 1'b1;
      ld.c0_oe_n = 1'b1;
      case (lc.protocol_select)
         usc_pkg::USC_PROT_UART: begin
            ld.d1_out = ld.tx_bit;
            ld.d1_oe_n = 1'b0;
         end
         usc_pkg::USC_PROT_SPI: begin
            if (lc.master) begin
               ld.c0_out = ld.st != usc_pkg::USC_LK_SHIFT;
               ld.c0_oe_n = 1'b0;
            end
            if (lc.half_duplex) begin
               ld.d0_out = ld.tx_bit;
               ld.d0_oe_n = !ld.dir;
            end else if (lc.master) begin
               ld.d0_out = ld.tx_bit;
               ld.d0_oe_n = 1'b0;
            end else begin
               ld.d1_out = ld.tx_bit;
               ld.d1_oe_n = ld.st != usc_pkg::USC_LK_SHIFT;
            end
         end
         usc_pkg::USC_PROT_I2C: begin
            ld.d0_out = 1'b0;
            ld.d0_oe_n = ld.tx_bit;
         end
         default: ld.d0_out = 1'b1;
      endcase

      if (lq.rst2) begin
         ld = usc_pkg::USC_LINK_RST;
      end
      ld.rst1 = i_srst;
      ld.rst2 = lq.rst1;
      ld.cfg1 = i_cfg;
      ld.cfg2 = lq.cfg1;
      ld.req1 = cq.tx_req;
      ld.req2 = lq.req1;
   end

   always_ff @(posedge i_link_clock) begin
      lq <= ld;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_rx_data = cq.rx_h0;
   assign o_rx_valid = cq.rx_cnt != 2'h0;
   assign o_rx_full = cq.rx_cnt == usc_pkg::USC_RX_DEPTH;
   assign o_tx_buf_empty = cq.tx_empty;
   assign o_tx_buf_full = !cq.tx_empty;
   assign o_tx_start_flag = cq.tx_st_f;
   assign o_tx_end_flag = cq.tx_end_f;
   assign o_rx_overrun_flag = cq.rx_ovr;
   assign o_cond_in = cond_in;
   assign o_edge_trigger = cq.trig;
   assign o_serial_clock_pin = cq.clk_out;
   assign o_serial_clock_pin_oe_n = cq.clk_oe_n;
   assign o_ctrl_pin_1 = cq.rts_n;
   assign o_ctrl_pin_1_oe_n = cq.rts_oe_n;
   assign o_ctrl_pin_0 = lq.c0_out;
   assign o_ctrl_pin_0_oe_n = lq.c0_oe_n;
   assign o_data_pin_0 = lq.d0_out;
   assign o_data_pin_0_oe_n = lq.d0_oe_n;
   assign o_data_pin_1 = lq.d1_out;
   assign o_data_pin_1_oe_n = lq.d1_oe_n;

endmodule // usc_serial_core

// ==== tb/usc_peer.sv ====
module usc_peer (
   // link side
   input wire logic i_link_clock,
   input wire logic i_level,
   // wires to and from the core
   input wire logic i_tx_pin,
   input wire logic i_tx_oe_n,
   output logic o_rx_pin,
   output logic [63:0] o_hist
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last = 1'b1;
   logic seen;
   // ---------------------------------------------------------------
   // line capture
   // ---------------------------------------------------------------
   // a released line shows the inverse of its last level
   assign seen = i_tx_oe_n ? ~last : i_tx_pin;
   always @(posedge i_link_clock) begin
      last <= seen;
      o_hist <= {o_hist[62:0], seen};
   end
   // the peer drives the receive data line with the level asked of it
   assign o_rx_pin = i_level;
endmodule // usc_peer

// ==== tb/usc_serial_core_chk.sv ====
module usc_chk (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // inputs
   input wire usc_pkg::usc_cfg_s i_cfg,
   input wire logic i_tx_write,
   input wire logic i_tx_buf_clear,
   input wire logic i_tx_start_flag_clear,
   input wire logic i_data_pin_0,
   input wire logic i_serial_clock_pin,
   // outputs
   input wire logic o_tx_buf_full,
   input wire logic o_tx_buf_empty,
   input wire logic o_tx_start_flag,
   input wire logic o_rx_full,
   input wire logic o_rx_valid,
   input wire logic o_rx_overrun_flag,
   input wire logic o_ctrl_pin_1,
   input wire logic [usc_pkg::USC_N_IN-1:0] o_cond_in
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   a_write_clears_empty: assert property (i_tx_write |=> !o_tx_buf_empty)
      else $error("empty flag stayed set after a write");
   a_full_empty_pair: assert property (o_tx_buf_full != o_tx_buf_empty)
      else $error("full and empty flags agree");
   a_clear_empties: assert property (i_tx_buf_clear && !i_tx_write |=> o_tx_buf_empty)
      else $error("buffer clear left data pending");
   a_start_sticky: assert property (o_tx_start_flag && !i_tx_start_flag_clear |=> o_tx_start_flag)
      else $error("start flag dropped without a clear");
   a_load_sets_start: assert property ($rose(o_tx_buf_empty) && !$past(i_tx_buf_clear)
      |-> o_tx_start_flag)
      else $error("holding word left without a start flag");
   a_start_needs_data: assert property ($rose(o_tx_start_flag) |-> !$past(o_tx_buf_empty))
      else $error("start flag without pending data");
   a_overrun_when_full: assert property ($rose(o_rx_overrun_flag) |-> $past(o_rx_full))
      else $error("overrun without two words held");
   a_full_is_valid: assert property (o_rx_full |-> o_rx_valid)
      else $error("full without valid");
   a_rts_when_full: assert property (i_cfg.protocol_select == usc_pkg::USC_PROT_UART
      && i_cfg.flow_ctrl && o_rx_full [*2] |-> o_ctrl_pin_1)
      else $error("request to send low while receive buffer full");
   a_data_raw_path: assert property (!i_cfg.data_sync
      |-> o_cond_in[0] == (i_data_pin_0 ^ i_cfg.data_invert))
      else $error("unsynchronised data input wrong");
   a_clock_no_invert: assert property (!i_cfg.clk_sync |-> o_cond_in[3] == i_serial_clock_pin)
      else $error("clock input altered");
   c_start: cover property ($rose(o_tx_start_flag));
   c_full: cover property ($rose(o_rx_full));
   c_overrun: cover property ($rose(o_rx_overrun_flag));
endmodule // usc_chk

bind usc_serial_core usc_chk chk_u (.i_clock(i_clock), .i_srst(i_srst), .i_cfg(i_cfg),
   .i_tx_write(i_tx_write), .i_tx_buf_clear(i_tx_buf_clear),
   .i_tx_start_flag_clear(i_tx_start_flag_clear), .i_data_pin_0(i_data_pin_0),
   .i_serial_clock_pin(i_serial_clock_pin), .o_tx_buf_full(o_tx_buf_full),
   .o_tx_buf_empty(o_tx_buf_empty), .o_tx_start_flag(o_tx_start_flag), .o_rx_full(o_rx_full),
   .o_rx_valid(o_rx_valid), .o_rx_overrun_flag(o_rx_overrun_flag),
   .o_ctrl_pin_1(o_ctrl_pin_1), .o_cond_in(o_cond_in));

// ==== tb/tb_usc_serial_core.sv ====
module tb_usc_serial_core;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clock = 1'b0, i_link_clock = 1'b0, i_srst = 1'b1;
   usc_pkg::usc_cfg_s i_cfg = '0;
   usc_pkg::usc_tx_word_s i_tx_word = '0;
   logic i_tx_write = 0, i_tx_buf_clear = 0, i_rx_read = 0, i_ctrl_pin_0 = 0, level = 1;
   logic st_clr = 0, end_clr = 0, ovr_clr = 0, d0, d1, d1_oe_n, c1;
   logic [15:0] rx_data;
   logic rx_valid, rx_full, full, empty, st_f, end_f, ovr_f;
   logic [3:0] cond;
   logic [1:0] trig;
   logic [63:0] hist, hist_s;
   logic d0o, d0o_oe_n;
   int bad_count = 0, check_count = 0, cyc = 0, k;
   always #25 i_clock = ~i_clock;
   always #6 i_link_clock = ~i_link_clock;
   usc_serial_core dut_u (.i_clock(i_clock), .i_srst(i_srst), .i_link_clock(i_link_clock),
      .i_cfg(i_cfg), .i_tx_write(i_tx_write), .i_tx_word(i_tx_word),
      .i_tx_buf_clear(i_tx_buf_clear), .i_rx_read(i_rx_read), .o_rx_data(rx_data),
      .o_rx_valid(rx_valid), .o_rx_full(rx_full), .o_tx_buf_full(full),
      .o_tx_buf_empty(empty), .o_tx_start_flag(st_f), .o_tx_end_flag(end_f),
      .o_rx_overrun_flag(ovr_f), .i_tx_start_flag_clear(st_clr),
      .i_tx_end_flag_clear(end_clr), .i_rx_overrun_clear(ovr_clr), .o_cond_in(cond),
      .o_edge_trigger(trig), .i_sclk_gen(1'b0), .i_serial_clock_pin(1'b0),
      .o_serial_clock_pin(), .o_serial_clock_pin_oe_n(), .i_ctrl_pin_0(i_ctrl_pin_0),
      .o_ctrl_pin_0(), .o_ctrl_pin_0_oe_n(), .o_ctrl_pin_1(c1), .o_ctrl_pin_1_oe_n(),
      .i_data_pin_0(d0), .o_data_pin_0(d0o), .o_data_pin_0_oe_n(d0o_oe_n), .i_data_pin_1(1'b1),
      .o_data_pin_1(d1), .o_data_pin_1_oe_n(d1_oe_n));
   usc_peer peer_u (.i_link_clock(i_link_clock), .i_level(level), .i_tx_pin(d1),
      .i_tx_oe_n(d1_oe_n), .o_rx_pin(d0), .o_hist(hist));
   // second peer watches the data out line used by a serial master
   usc_peer peer_s (.i_link_clock(i_link_clock), .i_level(1'b1), .i_tx_pin(d0o),
      .i_tx_oe_n(d0o_oe_n), .o_rx_pin(), .o_hist(hist_s));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(1);
   endtask
   task automatic write(input logic [15:0] d);
      i_tx_word = {1'b0, d};
      pulse(i_tx_write);
   endtask
   // configuration only changes while the core is disabled
   task automatic set_cfg(input logic flow, input logic sync, input logic inv);
      i_cfg.protocol_select = usc_pkg::USC_PROT_OFF;
      tick(4);
      i_cfg = '{protocol_select: usc_pkg::USC_PROT_UART, master: 1'b1, flow_ctrl: flow,
         word_len: 4'h7, data_sync: sync, data_invert: inv,
         edge_detect_sel: usc_pkg::USC_EDGE_FALL, default: 1'b0};
      tick(4);
   endtask
   function automatic logic found(input logic [63:0] h, input logic [7:0] p);
      for (int i = 0; i < 57; i++) if (h[i+:8] === p) return 1'b1;
      return 1'b0;
   endfunction
   task automatic flush();
      repeat (4) pulse(i_rx_read);
      pulse(ovr_clr);
      pulse(st_clr);
      pulse(end_clr);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk({full, empty, st_f, end_f, ovr_f, rx_valid}, 16'h0010);
   endtask
   task automatic t_tx();
      set_cfg(1'b0, 1'b0, 1'b0);
      write(16'h0035);
      chk({full, empty}, 16'h0002);
      for (k = 0; k < 300 && st_f !== 1'b1; k++) tick(1);
      chk(st_f, 1'b1);
      write(16'h000f);
      chk(empty, 1'b0);
      for (k = 0; k < 300 && empty !== 1'b1; k++) tick(1);
      chk(empty, 1'b1);
      tick(4);
      chk(end_f, 1'b1);
      chk(found(hist, 8'hac), 1'b1);
      chk(found(hist, 8'hf0), 1'b1);
      flush();
   endtask
   task automatic t_flow();
      set_cfg(1'b1, 1'b0, 1'b0);
      i_ctrl_pin_0 = 1'b1;
      write(16'h0011);
      tick(40);
      chk({empty, st_f}, 16'h0000);
      pulse(i_tx_buf_clear);
      tick(1);
      chk(empty, 1'b1);
      i_ctrl_pin_0 = 1'b0;
      tick(40);
      chk(st_f, 1'b0);
   endtask
   task automatic t_rx();
      for (int w = 0; w < 3; w++) begin
         level = (w != 1);
         write(16'h0000);
         for (k = 0; k < 300 && empty !== 1'b1; k++) tick(1);
         tick(8);
      end
      chk({rx_full, ovr_f, 6'h00, rx_data[7:0]}, 16'hc0ff);
      chk(c1, 1'b1);
      pulse(i_rx_read);
      tick(2);
      chk({rx_valid, rx_full, 6'h00, rx_data[7:0]}, 16'h8000);
      pulse(i_rx_read);
      tick(2);
      chk(rx_valid, 1'b0);
      pulse(i_rx_read);
      tick(2);
      chk({rx_valid, ovr_f}, 16'h0001);
      pulse(ovr_clr);
      chk(ovr_f, 1'b0);
   endtask
   task automatic t_input();
      set_cfg(1'b0, 1'b1, 1'b0);
      level = 1'b0;
      #1 chk(cond[0], 1'b1);
      for (k = 0; k < 8 && trig[0] !== 1'b1; k++) tick(1);
      chk(trig[0], 1'b1);
      chk(cond[0], 1'b0);
      tick(4);
      level = 1'b1;
      for (k = 0; k < 8 && trig[0] !== 1'b1; k++) tick(1);
      chk(trig[0], 1'b0);
      set_cfg(1'b0, 1'b0, 1'b1);
      #1 chk({cond[3], cond[0]}, 16'h0000);
   endtask
   // serial master, sixteen bit word, most significant bit first
   task automatic t_spi();
      i_cfg.protocol_select = usc_pkg::USC_PROT_OFF;
      tick(4);
      i_cfg = '{protocol_select: usc_pkg::USC_PROT_SPI, master: 1'b1, word_len: 4'hf,
         msb_first: 1'b1, default: 1'b0};
      tick(4);
      write(16'ha5c3);
      for (k = 0; k < 300 && empty !== 1'b1; k++) tick(1);
      chk(empty, 1'b1);
      tick(8);
      chk(found(hist_s, 8'ha5) & found(hist_s, 8'hc3), 1'b1);
      chk(rx_valid, 1'b1);
      chk(rx_data, 16'hffff);
   endtask
   // ---------------------------------------------------------------
   // run control
   // ---------------------------------------------------------------
   task automatic wrap_up();
      if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      tick(5);
      i_srst = 1'b0;
      tick(2);
      t_reset();
      t_tx();
      t_flow();
      t_rx();
      t_input();
      t_spi();
      wrap_up();
   end
endmodule // tb_usc_serial_core
